// >>> hdl/rtl_limit_table.sv
// unadjusted replay limit lookup by payload setting and link width
`timescale 1ns/1ps
module rtl_limit_table (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // lookup port
    rtl_lim_if.prov lim
);
    logic [15:0] next_limit;
    logic [15:0] limit;

    // out-of-range codes fall back to the longest entry in their axis
    function automatic logic [15:0] rtl_lookup(input logic [2:0] pay, input logic [2:0] wid);
        logic [2:0] p;
        logic [2:0] w;
        p = (pay > rtl_pkg::PAYLOAD_MAX_CODE) ? rtl_pkg::PAYLOAD_MAX_CODE : pay;
        w = (wid > rtl_pkg::WIDTH_MAX_CODE) ? rtl_pkg::WIDTH_X1_CODE : wid;
        return rtl_pkg::LIMIT_TBL[p][w];
    endfunction

    always_comb begin
        next_limit = rtl_lookup(lim.payload_code, lim.width_code);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            limit <= rtl_pkg::LIMIT_TBL[0][0];
        end else begin
            limit <= next_limit;
        end
    end

    assign lim.unadj_limit = limit;

    // smallest entry still covers overhead plus the delay twice over
    tbl_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
        limit >= 16'(rtl_pkg::PACKET_OVERHEAD_CONST + 2 * rtl_pkg::PROCESSING_DELAY_CONST))
        else $error("limit table entry below fixed overhead floor");
    tbl_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 limit == rtl_lookup($past(lim.payload_code), $past(lim.width_code)))
        else $error("limit does not follow payload and width");
endmodule

// >>> hdl/rtl_replay_timer.sv
// replay timeout timer with apb registers and attribute cleaner
`timescale 1ns/1ps
module rtl_replay_timer #(
    parameter int CNT_W = 17
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link layer events, same clock
    input wire logic sym_tick,
    input wire logic tx_pkt_done,
    input wire logic ack_progress,
    input wire logic nak_rcvd,
    input wire logic unacked,
    input wire logic retrain,
    input wire logic tx_busy,
    input wire logic rx_wake_busy,
    // replay request
    output logic replay_start,
    output logic replay_cause,
    // request attribute cleaner
    input wire logic [2:0] req_kind,
    input wire logic req_ro,
    input wire logic req_ns,
    input wire logic req_permit,
    output logic out_ro,
    output logic out_ns,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {
        S_IDLE,
        S_RUN,
        S_DUE,
        S_HOLD
    } rtl_state_t;

    rtl_lim_if lim ();
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [15:0] wake_norm;
    logic [15:0] next_wake_norm;
    logic [15:0] wake_long;
    logic [15:0] next_wake_long;
    logic [2:0] status;
    logic [2:0] next_status;
    logic [2:0] mask;
    logic [2:0] next_mask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic wr_en;
    logic [6:0] cfg_key;
    logic [6:0] cfg_last;
    logic [1:0] reload;
    logic [1:0] next_reload;
    logic [CNT_W-1:0] eff_limit;
    logic [CNT_W-1:0] next_eff_limit;
    rtl_state_t state;
    rtl_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_replay_start;
    logic next_replay_cause;
    logic ev_timeout;
    logic ev_nak;
    logic ev_defer;
    logic next_out_ro;
    logic next_out_ns;
    logic attr_forced;

    function automatic logic rtl_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    rtl_limit_table u_table (
        .clk(clk),
        .rst_n(rst_n),
        .lim(lim)
    );

    // apb: one wait state, so the access phase takes two cycles
    assign wr_en = psel && penable && pready && pwrite;
    always_comb begin
        next_pready = psel && penable && !pready;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            if (rtl_hit(paddr, rtl_pkg::OFS_CTRL)) begin
                next_prdata = ctrl;
            end else if (rtl_hit(paddr, rtl_pkg::OFS_WAKE)) begin
                next_prdata = {wake_long, wake_norm};
            end else if (rtl_hit(paddr, rtl_pkg::OFS_STATUS)) begin
                next_prdata = {29'h0, status};
            end else if (rtl_hit(paddr, rtl_pkg::OFS_MASK)) begin
                next_prdata = {29'h0, mask};
            end else if (rtl_hit(paddr, rtl_pkg::OFS_LIMIT)) begin
                next_prdata = 32'(eff_limit);
            end else if (rtl_hit(paddr, rtl_pkg::OFS_COUNT)) begin
                next_prdata = 32'(cnt);
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        next_wake_norm = wake_norm;
        next_wake_long = wake_long;
        next_mask = mask;
        if (wr_en && rtl_hit(paddr, rtl_pkg::OFS_CTRL)) begin
            next_ctrl = pwdata;
        end
        if (wr_en && rtl_hit(paddr, rtl_pkg::OFS_WAKE)) begin
            next_wake_norm = pwdata[15:0];
            next_wake_long = pwdata[rtl_pkg::WAKE_LONG_LSB +: 16];
        end
        if (wr_en && rtl_hit(paddr, rtl_pkg::OFS_MASK)) begin
            next_mask = pwdata[2:0];
        end
        // write one clears, but a new event in the same cycle wins
        next_status = status;
        if (wr_en && rtl_hit(paddr, rtl_pkg::OFS_STATUS)) begin
            next_status = status & ~pwdata[2:0];
        end
        next_status[rtl_pkg::ST_TIMEOUT_BIT] = next_status[rtl_pkg::ST_TIMEOUT_BIT] | ev_timeout;
        next_status[rtl_pkg::ST_NAK_BIT] = next_status[rtl_pkg::ST_NAK_BIT] | ev_nak;
        next_status[rtl_pkg::ST_DEFER_BIT] = next_status[rtl_pkg::ST_DEFER_BIT] | ev_defer;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= rtl_pkg::CTRL_RESET;
            wake_norm <= rtl_pkg::WAKE_NORM_RESET;
            wake_long <= rtl_pkg::WAKE_LONG_RESET;
            mask <= rtl_pkg::MASK_RESET;
            status <= 3'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            wake_norm <= next_wake_norm;
            wake_long <= next_wake_long;
            mask <= next_mask;
            status <= next_status;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    // limit selection: lookup is one cycle behind, so reload two cycles after a change
    assign lim.payload_code = ctrl[rtl_pkg::CTRL_PAYLOAD_LSB +: 3];
    assign lim.width_code = ctrl[rtl_pkg::CTRL_WIDTH_LSB +: 3];
    assign cfg_key = {ctrl[rtl_pkg::CTRL_LONG_SYNC_BIT], lim.payload_code, lim.width_code};
    always_comb begin
        next_reload = {reload[0], 1'b0};
        // a new wake allowance must reach the limit too, not only a new key
        if ((cfg_key != cfg_last) || (wr_en && rtl_hit(paddr, rtl_pkg::OFS_WAKE))) begin
            next_reload = 2'h3;
        end
        next_eff_limit = eff_limit;
        if (reload[1]) begin
            // table already holds the formula without the wake term
            next_eff_limit = CNT_W'(lim.unadj_limit) + CNT_W'(ctrl[rtl_pkg::CTRL_LONG_SYNC_BIT]
                ? wake_long : wake_norm);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_last <= 7'h00;
            reload <= rtl_pkg::RELOAD_RESET;
            eff_limit <= CNT_W'(rtl_pkg::LIMIT_TBL[0][0]);
        end else begin
            cfg_last <= cfg_key;
            reload <= next_reload;
            eff_limit <= next_eff_limit;
        end
    end

    // retry wait counter
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_replay_start = 1'b0;
        next_replay_cause = replay_cause;
        ev_timeout = 1'b0;
        ev_nak = 1'b0;
        ev_defer = 1'b0;
        case (state)
            S_IDLE: begin
                next_cnt = '0;
                if (tx_pkt_done && unacked) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                if (!unacked) begin
                    next_state = S_IDLE;
                    next_cnt = '0;
                end else if (nak_rcvd) begin
                    next_state = S_DUE;
                    next_replay_cause = rtl_pkg::CAUSE_NAK;
                    next_cnt = '0;
                    ev_nak = 1'b1;
                end else if (ack_progress) begin
                    next_cnt = '0;
                end else if (cnt >= eff_limit) begin
                    if (rx_wake_busy) begin
                        ev_defer = 1'b1;
                    end else begin
                        next_state = S_DUE;
                        next_replay_cause = rtl_pkg::CAUSE_TIMEOUT;
                        next_cnt = '0;
                        ev_timeout = 1'b1;
                    end
                end else if (sym_tick && !retrain) begin
                    next_cnt = cnt + 1'b1;
                end
            end
            S_DUE: begin
                if (!unacked) begin
                    next_state = S_IDLE;
                end else if (!tx_busy) begin
                    next_state = S_HOLD;
                    next_replay_start = 1'b1;
                end
            end
            S_HOLD: begin
                next_cnt = '0;
                if (!unacked) begin
                    next_state = S_IDLE;
                end else if (tx_pkt_done) begin
                    next_state = S_RUN;
                end
            end
            default: begin
                next_state = S_IDLE;
                next_cnt = '0;
            end
        endcase
        if (!ctrl[rtl_pkg::CTRL_EN_BIT]) begin
            next_state = S_IDLE;
            next_cnt = '0;
            next_replay_start = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cnt <= '0;
            replay_start <= 1'b0;
            replay_cause <= rtl_pkg::CAUSE_TIMEOUT;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            replay_start <= next_replay_start;
            replay_cause <= next_replay_cause;
        end
    end

    // attribute cleaner: without req_permit, only plain memory and completions keep their attributes
    always_comb begin
        attr_forced = !req_permit && (req_kind != rtl_pkg::KIND_MEM)
            && (req_kind != rtl_pkg::KIND_CPL);
        next_out_ro = req_ro && !attr_forced;
        next_out_ns = req_ns && !attr_forced;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_ro <= 1'b0;
            out_ns <= 1'b0;
        end else begin
            out_ro <= next_out_ro;
            out_ns <= next_out_ns;
        end
    end

    no_early_expiry_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_RUN) ##1 (state == S_DUE) && $past(!nak_rcvd) |-> $past(cnt >= eff_limit))
        else $error("replay due before limit reached");
    expiry_fires_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_RUN) && unacked && !nak_rcvd && !ack_progress && (cnt >= eff_limit)
        && !rx_wake_busy && ctrl[0] |=> (state == S_DUE) && (cnt == '0))
        else $error("expiry did not raise replay");
    nak_replay_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_RUN) && unacked && nak_rcvd && ctrl[0] |=> (state == S_DUE)
        && (replay_cause == rtl_pkg::CAUSE_NAK))
        else $error("nak did not raise replay");
    wake_defer_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_RUN) && rx_wake_busy && unacked && !nak_rcvd |=> (state != S_DUE))
        else $error("replay fired while ack link waking");
    tick_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_RUN) && (cnt < eff_limit) ##1 (state == S_RUN) && (cnt != '0)
        |-> cnt == $past(cnt) + CNT_W'($past(sym_tick && !retrain)))
        else $error("counter step wrong");
    hold_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        replay_start |-> $past(!tx_busy) && ($past(state) == S_DUE))
        else $error("replay started over busy transmitter");
    limit_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
        reload[1] |=> eff_limit == CNT_W'($past(lim.unadj_limit)) + CNT_W'($past(
        ctrl[rtl_pkg::CTRL_LONG_SYNC_BIT]) ? $past(wake_long) : $past(wake_norm)))
        else $error("effective limit not table plus wake allowance");
    reload_on_change_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_key != cfg_last) |=> ##1 reload[1])
        else $error("limit not reloaded after setting change");
    attr_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req_kind inside {rtl_pkg::KIND_CFG, rtl_pkg::KIND_TRUSTED_CFG, rtl_pkg::KIND_IO,
        rtl_pkg::KIND_MEM_MSI, rtl_pkg::KIND_MSG}) && !req_permit |=> !out_ro && !out_ns)
        else $error("attribute not forced to zero");
    timeout_cov: cover property (@(posedge clk) disable iff (!rst_n) ev_timeout ##[1:20] replay_start);
    nak_cov: cover property (@(posedge clk) disable iff (!rst_n) ev_nak ##[1:20] replay_start);
    defer_cov: cover property (@(posedge clk) disable iff (!rst_n) ev_defer ##1 !rx_wake_busy);
    irq_cov: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule

// >>> include/rtl_lim_if.sv
// carrier between the timer core and the limit lookup
`timescale 1ns/1ps
interface rtl_lim_if;
    logic [2:0] payload_code;
    logic [2:0] width_code;
    logic [15:0] unadj_limit;
    modport cons (output payload_code, output width_code, input unadj_limit);
    modport prov (input payload_code, input width_code, output unadj_limit);
endinterface

// >>> include/rtl_pkg.sv
// constants and types for the replay timeout limit block
package rtl_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAKE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_LIMIT = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    // control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_LONG_SYNC_BIT = 1;
    localparam int CTRL_PAYLOAD_LSB = 4;
    localparam int CTRL_WIDTH_LSB = 8;
    localparam int WAKE_LONG_LSB = 16;
    // status and mask bit positions
    localparam int ST_TIMEOUT_BIT = 0;
    localparam int ST_NAK_BIT = 1;
    localparam int ST_DEFER_BIT = 2;
    localparam int ST_BITS = 3;
    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] WAKE_NORM_RESET = 16'h0000;
    localparam logic [15:0] WAKE_LONG_RESET = 16'h0000;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [1:0] RELOAD_RESET = 2'h3;
    // fixed terms behind the limit table, in symbol times
    localparam int PACKET_OVERHEAD_CONST = 28;
    localparam int PROCESSING_DELAY_CONST = 19;
    localparam int TIMEOUT_MULT = 3;
    // table geometry and encodings
    localparam int N_PAYLOAD = 6;
    localparam int N_WIDTH = 7;
    localparam logic [2:0] PAYLOAD_MAX_CODE = 3'h5;
    localparam logic [2:0] WIDTH_X1_CODE = 3'h0;
    localparam logic [2:0] WIDTH_MAX_CODE = 3'h6;
    // unadjusted limits, rows 128..4096 bytes, columns x1 x2 x4 x8 x12 x16 x32
    localparam logic [15:0] LIMIT_TBL [0:N_PAYLOAD-1][0:N_WIDTH-1] = '{
        '{16'd711, 16'd384, 16'd219, 16'd201, 16'd174, 16'd144, 16'd99},
        '{16'd1248, 16'd651, 16'd354, 16'd321, 16'd270, 16'd216, 16'd135},
        '{16'd1677, 16'd867, 16'd462, 16'd258, 16'd327, 16'd258, 16'd156},
        '{16'd3213, 16'd1635, 16'd846, 16'd450, 16'd582, 16'd450, 16'd252},
        '{16'd6285, 16'd3171, 16'd1614, 16'd834, 16'd1095, 16'd834, 16'd444},
        '{16'd12429, 16'd6243, 16'd3150, 16'd1602, 16'd2118, 16'd1602, 16'd828}
    };
    // request kinds seen by the attribute cleaner
    typedef enum logic [2:0] {
        KIND_MEM = 3'h0,
        KIND_MEM_MSI = 3'h1,
        KIND_IO = 3'h2,
        KIND_CFG = 3'h3,
        KIND_TRUSTED_CFG = 3'h4,
        KIND_MSG = 3'h5,
        KIND_CPL = 3'h6
    } rtl_kind_t;
    typedef enum logic {
        CAUSE_TIMEOUT,
        CAUSE_NAK
    } rtl_cause_t;
endpackage

// >>> sim/rtl_link_partner.sv
// link partner model: answers with acks, naks and a receiver wake indication
`timescale 1ns/1ps
module rtl_link_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // commands from the bench
    input wire logic ack_cmd,
    input wire logic [3:0] ack_lag,
    input wire logic nak_cmd,
    input wire logic wake_cmd,
    // toward the timer
    output logic ack_progress,
    output logic nak_rcvd,
    output logic rx_wake_busy
);
    int lag;

    // an ack comes back late by ack_lag plus one cycles, as a slow partner would answer
    always @(posedge clk) begin
        ack_progress <= 1'b0;
        nak_rcvd <= nak_cmd & rst_n;
        rx_wake_busy <= wake_cmd & rst_n;
        if (!rst_n) begin
            lag <= 0;
        end else if (ack_cmd) begin
            lag <= int'(ack_lag) + 1;
        end else if (lag > 0) begin
            ack_progress <= (lag == 1);
            lag <= lag - 1;
        end
    end
endmodule

// >>> sim/tb_replay_timeout_limit.sv
// self-checking bench for the replay timeout limit block
`timescale 1ns/1ps
module tb_replay_timeout_limit;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ack_progress, nak_rcvd, rx_wake_busy;
    logic sym_tick = 1'b0, tx_pkt_done = 1'b0, unacked = 1'b0, tx_busy = 1'b0, retrain = 1'b0;
    logic ack_cmd = 1'b0, nak_cmd = 1'b0, wake_cmd = 1'b0;
    logic [3:0] ack_lag = 4'h0;
    logic [2:0] req_kind = 3'h0;
    logic req_ro = 1'b0, req_ns = 1'b0, req_permit = 1'b0;
    logic replay_start, replay_cause, out_ro, out_ns, irq;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 29473;
    int lim, wake_n, wake_l, p, w, ls;

    initial begin
        forever #2 clk = ~clk;
    end

    // retrain is raised in the nak scenario to show the counter freezing
    rtl_replay_timer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sym_tick(sym_tick), .tx_pkt_done(tx_pkt_done),
        .ack_progress(ack_progress), .nak_rcvd(nak_rcvd), .unacked(unacked), .retrain(retrain),
        .tx_busy(tx_busy), .rx_wake_busy(rx_wake_busy), .replay_start(replay_start),
        .replay_cause(replay_cause), .req_kind(req_kind), .req_ro(req_ro), .req_ns(req_ns),
        .req_permit(req_permit), .out_ro(out_ro), .out_ns(out_ns), .irq(irq));
    rtl_link_partner i_partner (.clk(clk), .rst_n(rst_n), .ack_cmd(ack_cmd),
        .ack_lag(ack_lag), .nak_cmd(nak_cmd), .wake_cmd(wake_cmd),
        .ack_progress(ack_progress), .nak_rcvd(nak_rcvd), .rx_wake_busy(rx_wake_busy));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; ends with an idle edge so back to back calls never collide
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 1, 0);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    function automatic int exp_limit(int pc, int wc, int lsb);
        if (pc > 5) pc = 5;
        if (wc > 6) wc = 0;
        return int'(rtl_pkg::LIMIT_TBL[pc][wc]) + (lsb != 0 ? wake_l : wake_n);
    endfunction

    task automatic set_ctrl(input int en, input int pc, input int wc, input int lsb);
        apb(1'b1, rtl_pkg::OFS_CTRL, 32'(en) | 32'(lsb << 1) | 32'(pc << 4) | 32'(wc << 8));
        lim = exp_limit(pc, wc, lsb);
        repeat (3) @(posedge clk);
    endtask

    // a dropped unacked first puts the timer back to idle
    task automatic start_run();
        unacked <= 1'b0;
        @(posedge clk);
        unacked <= 1'b1;
        tx_pkt_done <= 1'b1;
        sym_tick <= 1'b1;
        @(posedge clk);
        tx_pkt_done <= 1'b0;
    endtask

    task automatic wait_replay(input int lo, input int hi, input logic cause);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (replay_start !== 1'b1 && n < hi);
        if (replay_start !== 1'b1) begin
            chk("replay_start", 1, 0);
            report_and_stop();
        end
        chk("replay not early", 1, n >= lo);
        chk("replay_cause", cause, replay_cause);
    endtask

    task automatic hold_test(input logic wake);
        start_run();
        wake_cmd <= wake;
        tx_busy <= ~wake;
        repeat (lim + 10) begin
            @(posedge clk);
            chk("replay held", 0, replay_start);
        end
        wake_cmd <= 1'b0;
        tx_busy <= 1'b0;
        wait_replay(1, 8, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("ctrl", rtl_pkg::OFS_CTRL, 32'h0);
        rchk("mask", rtl_pkg::OFS_MASK, 32'h0);
        rchk("status", rtl_pkg::OFS_STATUS, 32'h0);
        rchk("limit", rtl_pkg::OFS_LIMIT, 32'd711);
        rchk("count", rtl_pkg::OFS_COUNT, 32'h0);
        apb(1'b1, 8'h18, 32'h1);
        chk("pslverr", 1, err);
        apb(1'b1, rtl_pkg::OFS_LIMIT, 32'hffff);
        rchk("limit ro", rtl_pkg::OFS_LIMIT, 32'd711);
        $display("test registers done");
        wake_n = $random(seed) & 32'h1f;
        wake_l = ($random(seed) & 32'h3f) + 32;
        apb(1'b1, rtl_pkg::OFS_WAKE, 32'(wake_n) | 32'(wake_l << 16));
        repeat (10) begin
            p = $random(seed) & 7;
            w = $random(seed) & 7;
            ls = $random(seed) & 1;
            set_ctrl(0, p, w, ls);
            rchk("limit", rtl_pkg::OFS_LIMIT, 32'(lim));
        end
        $display("test limit table done");
        apb(1'b1, rtl_pkg::OFS_MASK, 32'h7);
        set_ctrl(1, 0, 6, 0);
        start_run();
        wait_replay(lim, lim + 6, 1'b0);
        rchk("status", rtl_pkg::OFS_STATUS, 32'h1);
        chk("irq", 1, irq);
        apb(1'b1, rtl_pkg::OFS_STATUS, 32'h1);
        @(posedge clk);
        chk("irq cleared", 0, irq);
        $display("test timeout done");
        start_run();
        retrain <= 1'b1;
        repeat (20) @(posedge clk);
        retrain <= 1'b0;
        rchk("count frozen", rtl_pkg::OFS_COUNT, 32'h1);
        nak_cmd <= 1'b1;
        @(posedge clk);
        nak_cmd <= 1'b0;
        wait_replay(1, 8, 1'b1);
        rchk("status", rtl_pkg::OFS_STATUS, 32'h2);
        $display("test nak done");
        set_ctrl(1, 1, 5, 1);
        start_run();
        repeat (40) @(posedge clk);
        ack_lag <= 4'($random(seed) & 7);
        ack_cmd <= 1'b1;
        @(posedge clk);
        ack_cmd <= 1'b0;
        wait_replay(lim, lim + 16, 1'b0);
        $display("test ack restart done");
        hold_test(1'b0);
        apb(1'b1, rtl_pkg::OFS_STATUS, 32'h7);
        hold_test(1'b1);
        rchk("status", rtl_pkg::OFS_STATUS, 32'h5);
        $display("test hold off done");
        for (int k = 0; k < 14; k++) begin
            req_kind <= 3'(k % 7);
            req_ro <= 1'($random(seed));
            req_ns <= 1'($random(seed));
            req_permit <= 1'($random(seed));
            @(posedge clk);
            @(posedge clk);
            ls = (k % 7 == 0 || k % 7 == 6 || req_permit);
            chk("out_ro", req_ro & ls[0], out_ro);
            chk("out_ns", req_ns & ls[0], out_ns);
        end
        $display("test attributes done");
        report_and_stop();
    end
endmodule
